// ==== src/sadc_device.sv ====
// Purpose: converter end of the control port, digital model of the SAR timing
// Assumes: pins synchronous to core_clk_i; sample value given on sample_i
// Notes: busy low for CONV_CYCLES cycles; conversion fed by a 4-word FIFO
// Summary of operation
// - start only on falling read/convert, enables low
// - host holds read/convert low 40 ns
// - busy low until result latched
// - busy low: outputs off, inputs ignored
// - read mode: high shows old result
// - convert mode: outputs off at fall
// - convert mode: host returns line high during conversion
// - tracking resumes when conversion completes
// - high byte: top nibble low, zeros
// - chip select high: nothing, outputs off
// - full word with high byte enable low
// - high byte arrangement when enable high
// - fall with high byte enable: no start
// - stand-alone: selects tied low
// - convert mode: host reads on busy rising
// - conversion done within 2.7 us
`timescale 1ns/1ps
`default_nettype none
module sadc_device #(
   parameter int unsigned CONV_CYCLES = sadc_pkg::CONV_CYC,
   parameter int unsigned FIFO_DEPTH = 4
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   sadc_if.dev pins,
   // offset binary sample values; invalid means stall tracking on last value
   input wire logic sample_valid_i,
   output logic sample_ready_o,
   input wire logic [sadc_pkg::RES_W-1:0] sample_i,
   output logic tracking_o
);
   initial begin
      if (CONV_CYCLES < 1 || CONV_CYCLES > sadc_pkg::CONV_CYC) $error("conversion too long");
      if (sadc_pkg::BUS_W != sadc_pkg::RES_W) $error("data lines must carry the whole word");
      if (sadc_pkg::LOW_BYTE_W + sadc_pkg::HIGH_NIB_W != sadc_pkg::RES_W) begin
         $error("byte split must cover the word");
      end
      if (sadc_pkg::HIGH_NIB_W > sadc_pkg::LOW_BYTE_W) $error("top bits must fit the low byte");
   end
   typedef enum logic [1:0] {
      SADC_TRACK = 2'b01,
      SADC_CONV = 2'b10
   } sadc_state_t;
   typedef struct packed {
      sadc_state_t st;
      logic [11:0] cnt;
      logic rc_prev;
      logic [sadc_pkg::RES_W-1:0] held;
      logic [sadc_pkg::RES_W-1:0] result;
      logic [sadc_pkg::RES_W-1:0] track;
      logic busy_n;
      logic oe;
      logic [sadc_pkg::BUS_W-1:0] dout;
   } sadc_dev_t;
   sadc_dev_t s_q;
   sadc_dev_t s_d;
   logic f_valid;
   logic [sadc_pkg::RES_W-1:0] f_data;
   logic start;
   logic read_en;
   logic [sadc_pkg::BUS_W-1:0] line_word;
   logic [sadc_pkg::BUS_W-1:0] line_byte;
   // per data line: full word, or top bits on the low lines with the rest low
   for (genvar b = 0; b < sadc_pkg::BUS_W; b++) begin : g_line
      assign line_word[b] = s_q.result[b];
      if (b < sadc_pkg::HIGH_NIB_W) begin : g_top
         assign line_byte[b] = s_q.result[sadc_pkg::LOW_BYTE_W + b];
      end else begin : g_low
         assign line_byte[b] = 1'b0;
      end
   end
   sadc_fifo #(.WIDTH(sadc_pkg::RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(sample_valid_i),
      .in_ready_o(sample_ready_o),
      .in_data_i(sample_i),
      .out_valid_o(f_valid),
      .out_ready_i(s_q.st == SADC_TRACK),
      .out_data_o(f_data)
   );
   // falling edge with chip select and high byte low, not busy
   assign start = s_q.rc_prev && !pins.read_conv && !pins.chip_sel_n
      && !pins.high_byte_enable && s_q.busy_n;
   assign read_en = !pins.chip_sel_n && pins.read_conv && s_q.busy_n;
   always_comb begin
      s_d = s_q;
      s_d.rc_prev = pins.read_conv;
      unique case (s_q.st)
         SADC_TRACK: begin
            if (f_valid) begin
               s_d.track = f_data;
            end
            if (start) begin
               s_d.held = s_q.track;
               s_d.st = SADC_CONV;
               s_d.cnt = 12'h000;
               s_d.busy_n = 1'b0;
            end
         end
         SADC_CONV: begin
            // inputs ignored while converting
            if (s_q.cnt == 12'(CONV_CYCLES - 1)) begin
               s_d.result = s_q.held;
               s_d.busy_n = 1'b1;
               s_d.st = SADC_TRACK;
            end else begin
               s_d.cnt = s_q.cnt + 12'h001;
            end
         end
      endcase
      // output buffers follow the pins, forced off while busy
      s_d.oe = read_en && s_d.busy_n && !start;
      // result only changes while busy, so the registered copy is current once enabled
      if (pins.high_byte_enable) begin
         s_d.dout = line_byte;
      end else begin
         s_d.dout = line_word;
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         s_q <= '{st: SADC_TRACK, cnt: 12'h000, rc_prev: 1'b0,
            held: sadc_pkg::RESULT_RST, result: sadc_pkg::RESULT_RST,
            track: sadc_pkg::MID_SCALE, busy_n: 1'b1, oe: 1'b0,
            dout: sadc_pkg::RESULT_RST};
      end else begin
         s_q <= s_d;
      end
   end
   assign pins.busy_n = s_q.busy_n;
   assign pins.data_oe = s_q.oe;
   assign pins.data_out = s_q.dout;
   assign tracking_o = (s_q.st == SADC_TRACK);
endmodule : sadc_device
`default_nettype wire

// ==== src/sadc_fifo.sv ====
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: DEPTH a power of two
// Notes: full and empty from a count
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 4
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be power of two");
   end
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;
   assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data_i;
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
      end
   end
endmodule : sadc_fifo
`default_nettype wire

// ==== src/sadc_host.sv ====
// Purpose: host end: issues conversions and reads results
// Assumes: one request at a time on req_i
// Notes: convert mode pulses low; read mode pulses high; byte mode two reads, plus a full-word read in read mode
`timescale 1ns/1ps
`default_nettype none
module sadc_host #(
   parameter int unsigned PULSE_CYCLES = sadc_pkg::PULSE_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   sadc_if.host pins,
   input wire logic req_i,
   input wire logic read_mode_i,
   input wire logic byte_mode_i,
   output logic ready_o,
   output logic done_o,
   output logic [sadc_pkg::RES_W-1:0] result_o
);
   initial begin
      if (PULSE_CYCLES < sadc_pkg::PULSE_CYC || PULSE_CYCLES > 255) $error("pulse too short");
   end
   typedef enum logic [5:0] {
      SADC_IDLE = 6'b000001,
      SADC_LOW = 6'b000010,
      SADC_WAIT = 6'b000100,
      SADC_LO_B = 6'b001000,
      SADC_HI_B = 6'b010000,
      SADC_RISE = 6'b100000
   } sadc_hstate_t;
   typedef struct packed {
      sadc_hstate_t st;
      logic [7:0] cnt;
      logic rmode;
      logic bmode;
      logic rc;
      logic hi_byte;
      logic busy_prev;
      logic done;
      logic [sadc_pkg::RES_W-1:0] res;
   } sadc_host_t;
   sadc_host_t h_q;
   sadc_host_t h_d;
   always_comb begin
      h_d = h_q;
      h_d.done = 1'b0;
      h_d.busy_prev = pins.busy_n;
      unique case (h_q.st)
         SADC_IDLE: begin
            h_d.hi_byte = 1'b0;
            if (req_i && pins.busy_n) begin
               h_d.rmode = read_mode_i;
               h_d.bmode = byte_mode_i;
               if (read_mode_i) begin
                  h_d.rc = 1'b1;
                  h_d.st = SADC_LO_B;
               end else if (h_q.rc) begin
                  h_d.rc = 1'b0;
                  h_d.st = SADC_LOW;
               end else begin
                  // line idles low after read mode: raise it so a fall can follow
                  h_d.rc = 1'b1;
                  h_d.st = SADC_RISE;
               end
               h_d.cnt = 8'h00;
            end
         end
         SADC_RISE: begin
            h_d.rc = 1'b0;
            h_d.st = SADC_LOW;
            h_d.cnt = 8'h00;
         end
         SADC_LOW: begin
            // hold low the least pulse width; convert mode releases during conversion
            if (h_q.cnt == 8'(PULSE_CYCLES - 1)) begin
               h_d.rc = !h_q.rmode; // read mode idles low
               h_d.st = h_q.rmode ? SADC_IDLE : SADC_WAIT;
               h_d.done = h_q.rmode;
            end else begin
               h_d.cnt = h_q.cnt + 8'h01;
            end
         end
         SADC_WAIT: begin
            if (pins.busy_n && !h_q.busy_prev) begin
               h_d.st = SADC_LO_B;
               h_d.cnt = 8'h00;
            end
         end
         SADC_LO_B: begin
            // two cycles for outputs to settle, then sample
            h_d.cnt = h_q.cnt + 8'h01;
            if (h_q.cnt == 8'h02) begin
               h_d.res = pins.data_bus;
               h_d.cnt = 8'h00;
               if (h_q.bmode) begin
                  h_d.hi_byte = 1'b1;
                  h_d.st = SADC_HI_B;
               end else if (h_q.rmode) begin
                  h_d.rc = 1'b0; // falling edge starts next conversion
                  h_d.st = SADC_LOW;
               end else begin
                  h_d.done = 1'b1;
                  h_d.st = SADC_IDLE;
               end
            end
         end
         SADC_HI_B: begin
            h_d.cnt = h_q.cnt + 8'h01;
            if (h_q.cnt == 8'h02) begin
               h_d.res = {pins.data_bus[sadc_pkg::HIGH_NIB_W-1:0],
                  h_q.res[sadc_pkg::LOW_BYTE_W-1:0]};
               h_d.hi_byte = 1'b0; // must be low before any start
               h_d.cnt = 8'h00;
               if (h_q.rmode) begin
                  h_d.st = SADC_LO_B;
                  h_d.bmode = 1'b0;
               end else begin
                  h_d.done = 1'b1;
                  h_d.st = SADC_IDLE;
               end
            end
         end
      endcase
   end
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         h_q <= '{st: SADC_IDLE, cnt: 8'h00, rmode: 1'b0, bmode: 1'b0, rc: 1'b1,
            hi_byte: 1'b0, busy_prev: 1'b1, done: 1'b0, res: sadc_pkg::RESULT_RST};
      end else begin
         h_q <= h_d;
      end
   end
   assign pins.chip_sel_n = 1'b0;
   assign pins.read_conv = h_q.rc;
   assign pins.high_byte_enable = h_q.hi_byte;
   assign ready_o = (h_q.st == SADC_IDLE) && pins.busy_n;
   assign done_o = h_q.done;
   assign result_o = h_q.res;
endmodule : sadc_host
`default_nettype wire

// ==== src/sadc_if.sv ====
// Purpose: pin-level link between converter and host
// Assumes: data lines three-state, resolved here from the enable
// Notes: data_bus shows all ones where nobody drives
`timescale 1ns/1ps
`default_nettype none
interface sadc_if;
   logic chip_sel_n;
   logic read_conv;
   logic high_byte_enable;
   logic busy_n;
   logic [sadc_pkg::BUS_W-1:0] data_out;
   logic data_oe;
   logic [sadc_pkg::BUS_W-1:0] data_bus;
   assign data_bus = data_oe ? data_out : {sadc_pkg::BUS_W{1'b1}};
   modport dev (input chip_sel_n, input read_conv, input high_byte_enable,
      output busy_n, output data_out, output data_oe);
   modport host (output chip_sel_n, output read_conv, output high_byte_enable,
      input busy_n, input data_bus);
endinterface : sadc_if
`default_nettype wire

// ==== src/sadc_pkg.sv ====
// Purpose: shared constants and types for the sampling converter control port
// Assumes: one 50 MHz clock, synchronous active-low reset
// Notes: times kept in ns, cycle counts derived from the clock rate
package sadc_pkg;
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned RES_W = 12;
   localparam int unsigned BUS_W = 12;
   localparam int unsigned LOW_BYTE_W = 8;
   localparam int unsigned HIGH_NIB_W = 4;
   // longest conversion, 2.7 us
   localparam int unsigned CONV_MAX_NS = 2700;
   localparam int unsigned CONV_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   // least low time of the read/convert pulse, 40 ns
   localparam int unsigned PULSE_MIN_NS = 40;
   localparam int unsigned PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
   localparam logic [RES_W-1:0] MID_SCALE = 12'h800;
endpackage : sadc_pkg

// ==== test/sadc_monitor.sv ====
// Purpose: pin checks on the host to converter link
// Assumes: one clock, synchronous active-low reset
// Notes: data pins are a registered copy of the controls
`timescale 1ns/1ps
`default_nettype none
module sadc_monitor #(
   parameter int unsigned CONV_CYCLES = sadc_pkg::CONV_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic chip_sel_n,
   input wire logic read_conv,
   input wire logic high_byte_enable,
   input wire logic busy_n,
   input wire logic [sadc_pkg::BUS_W-1:0] data_out,
   input wire logic data_oe
);
   int unsigned cnt_q;
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i || busy_n) begin
         cnt_q <= 0;
      end else begin
         cnt_q <= cnt_q + 1;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_start_on_fall: assert property (
      !chip_sel_n && !high_byte_enable && busy_n && $fell(read_conv) |=> !busy_n)
      else $error("falling read line did not start");
   chk_start_cause: assert property (
      $fell(busy_n) |-> !$past(read_conv) && $past(read_conv, 2) && !$past(high_byte_enable)
      && !$past(chip_sel_n)) else $error("conversion began without a legal start");
   chk_busy_length: assert property (
      $rose(busy_n) |-> cnt_q == CONV_CYCLES) else $error("busy low for wrong length");
   chk_busy_bound: assert property (
      !busy_n |-> cnt_q < CONV_CYCLES) else $error("conversion overran");
   chk_busy_hiz: assert property (
      !busy_n |-> !data_oe) else $error("outputs driven while busy");
   chk_oe_cause: assert property (
      data_oe |-> busy_n && $past(read_conv) && !$past(chip_sel_n))
      else $error("outputs driven without read condition");
   chk_read_enable: assert property (
      $rose(read_conv) && busy_n && !chip_sel_n |=> data_oe) else $error("read edge left hi-z");
   chk_byte_zero: assert property (
      data_oe && $past(high_byte_enable) |-> data_out[11:4] == 8'h00)
      else $error("upper lines not low in byte mode");
   chk_high_nibble: assert property (
      data_oe && $past(data_oe) && $past(high_byte_enable) && !$past(high_byte_enable, 2)
      |-> data_out[3:0] == $past(data_out[11:8])) else $error("high nibble misplaced");
   cover property ($fell(busy_n));
   cover property (data_oe && high_byte_enable);
   cover property ($rose(read_conv) && busy_n);
endmodule : sadc_monitor
`default_nettype wire

// ==== test/sampling_adc_control_port_test.sv ====
// Purpose: host and converter end to end, plus a converter driven by hand
// Assumes: conversion count shortened to 8 cycles
// Notes: expected results queued by the driver, compared on done
`timescale 1ns/1ps
`default_nettype none
module sampling_adc_control_port_test;
   localparam int CONV = 8;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic req = 1'b0;
   logic rmode = 1'b0;
   logic bmode = 1'b0;
   logic rdy, done, s_ready, track, s2_ready;
   logic [11:0] res, last_conv;
   logic [11:0] smp = 12'h3c1;
   logic [31:0] lfsr = 32'h6b4e;
   logic [11:0] expq[$];
   int n_errors = 0;
   int samples_checked = 0;
   int i, k;
   sadc_if link ();
   sadc_if link2 ();
   sadc_host #(.PULSE_CYCLES(2)) i_sadc_host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
      .pins(link), .req_i(req), .read_mode_i(rmode), .byte_mode_i(bmode), .ready_o(rdy),
      .done_o(done), .result_o(res));
   sadc_device #(.CONV_CYCLES(CONV)) i_sadc_device (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .pins(link), .sample_valid_i(1'b1), .sample_ready_o(s_ready),
      .sample_i(smp), .tracking_o(track));
   sadc_device #(.CONV_CYCLES(CONV)) i_sadc_device_2 (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .pins(link2), .sample_valid_i(1'b1), .sample_ready_o(s2_ready),
      .sample_i(12'h5a3), .tracking_o());
   sadc_monitor #(.CONV_CYCLES(CONV)) i_sadc_monitor (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .chip_sel_n(link.chip_sel_n), .read_conv(link.read_conv),
      .high_byte_enable(link.high_byte_enable), .busy_n(link.busy_n),
      .data_out(link.data_out), .data_oe(link.data_oe));
   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic timeout(input string what);
      check(what, 12'h000, 12'h001);
      close_out();
   endtask : timeout
   task automatic idle_wait();
      for (i = 0; i < 400 && !(rdy === 1'b1 && link.busy_n === 1'b1); i++) @(negedge core_clk_i);
      if (i == 400) timeout("idle");
   endtask : idle_wait
   task automatic convert(input logic rm, input logic bm);
      idle_wait();
      check("tracking", {11'h0, track}, 12'h001);
      lfsr = lfsr_next(lfsr);
      smp = lfsr[11:0];
      repeat (10) @(negedge core_clk_i);
      expq.push_back(rm ? last_conv : smp);
      last_conv = smp;
      req = 1'b1;
      rmode = rm;
      bmode = bm;
      idle_wait();
      @(negedge core_clk_i);
      req = 1'b0;
      for (i = 0; i < 400 && expq.size() != 0; i++) @(negedge core_clk_i);
      if (i == 400) timeout("done");
   endtask : convert
   // one cycle of hand-driven pins on the second link
   task automatic drive2(input logic cs_n, input logic rc, input logic hi_byte);
      link2.chip_sel_n = cs_n;
      link2.read_conv = rc;
      link2.high_byte_enable = hi_byte;
      @(negedge core_clk_i);
   endtask : drive2
   task automatic hand_driven();
      drive2(1'b0, 1'b1, 1'b1);
      drive2(1'b0, 1'b0, 1'b1);
      repeat (3) @(negedge core_clk_i);
      check("byte fall busy", {11'h0, link2.busy_n}, 12'h001);
      check("byte low bus", link2.data_bus, 12'hfff);
      drive2(1'b1, 1'b1, 1'b0);
      drive2(1'b1, 1'b0, 1'b0);
      repeat (3) @(negedge core_clk_i);
      check("deselect busy", {11'h0, link2.busy_n}, 12'h001);
      check("deselect bus", link2.data_bus, 12'hfff);
      drive2(1'b0, 1'b1, 1'b0);
      drive2(1'b0, 1'b0, 1'b0);
      drive2(1'b0, 1'b0, 1'b0);
      drive2(1'b0, 1'b1, 1'b1);
      drive2(1'b0, 1'b0, 1'b0);
      drive2(1'b1, 1'b1, 1'b0);
      drive2(1'b0, 1'b1, 1'b0);
      check("fifo full", {11'h0, s2_ready}, 12'h000);
      check("busy bus", link2.data_bus, 12'hfff);
      for (k = 0; k < 400 && link2.busy_n !== 1'b1; k++) @(negedge core_clk_i);
      check("busy cycles", 12'(k), 12'(CONV - 5));
      repeat (10) @(negedge core_clk_i);
      check("fifo drained", {11'h0, s2_ready}, 12'h001);
      check("word", link2.data_bus, 12'h5a3);
      drive2(1'b0, 1'b1, 1'b1);
      repeat (2) @(negedge core_clk_i);
      check("high byte", link2.data_bus, 12'h005);
      drive2(1'b1, 1'b1, 1'b0);
      repeat (2) @(negedge core_clk_i);
      check("deselected", link2.data_bus, 12'hfff);
   endtask : hand_driven
   initial begin
      forever begin
         @(negedge core_clk_i);
         if (done === 1'b1) begin
            if (expq.size() == 0) begin
               check("result count", 12'h001, 12'h000);
            end else begin
               check("result", res, expq.pop_front());
            end
         end
      end
   end
   initial begin
      link2.chip_sel_n = 1'b0;
      link2.read_conv = 1'b1;
      link2.high_byte_enable = 1'b0;
      repeat (2) @(negedge core_clk_i);
      rst_n_i = 1'b1;
      for (k = 0; k < 8; k++) begin
         convert(k[0], k[1]);
      end
      hand_driven();
      close_out();
   end
endmodule : sampling_adc_control_port_test
`default_nettype wire
